// ==== rtl/rbms_reset_boot.sv ====
// reset distribution, boot-mode capture and boot interface setup
//
// Behaviour
// RULE1: system reset low initialises all state except the test hardware; o_boot_select is cleared only by i_reset and keeps its last code until release.
// RULE2: during system reset: internal resets active, oscillator running, PLL off.
// RULE3: test reset low clears only the factory test hardware.
// RULE4: board asserts test reset together with system reset.
// RULE5: boot select captured at system reset release picks the boot mode.
// RULE6: code 0001 boots as master from ROM on 2-wire port 0, 400kb/s.
// RULE7: code 0010 boots as slave over async serial port at 384Kb/s.
// RULE8: in SPI and 2-wire slave modes the external master sets the rate.
// RULE9: code 0111 boots as 2-wire ROM master on GPIO7/GPIO6 at 384Kb/s.
// RULE10: code 1100 boots as 2-wire slave answering address 1000100x.
// RULE11: reserved boot codes must not be selected; behaviour undefined.
// RULE12: boot interface is set to the listed speed before boot data moves.
// RULE13: host waits 2400000 ns after reset release before booting.
// RULE14: ROM boot access starts no sooner than 2650000 ns after release.
// RULE15: board should pull up the four boot select inputs.
// RULE16: pump outputs drive low in reset, later reassignable as GPIO.
// RULE17: aux audio and supply sync pins leave reset as inputs, reassignable.
`include "rbms_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module rbms_reset_boot #(
	parameter int unsigned ROM_DELAY_CYC  = `RBMS_ROM_DELAY_CYC,
	parameter int unsigned HOST_READY_CYC = `RBMS_HOST_READY_CYC
) (
	// clock and reset
	input  wire logic                    i_core_clk,
	input  wire logic                    i_reset,
	input  wire logic                    i_system_reset_n,
	input  wire logic                    i_test_logic_reset_n,
	// boot selection straps
	input  wire logic [3:0]              i_boot_select,
	// firmware pin reassignment after boot
	input  wire rbms_pkg::rbms_pins_t    i_pin_cfg,
	input  wire logic                    i_pin_cfg_load,
	// reset and clock controls
	output logic                         o_core_reset,
	output logic                         o_test_reset,
	output logic                         o_osc_enable,
	output logic                         o_pll_enable,
	// boot control
	output logic [3:0]                   o_boot_select,
	output rbms_pkg::rbms_boot_cfg_t     o_boot_cfg,
	output logic                         o_boot_start,
	output logic                         o_boot_invalid,
	output logic                         o_host_ready,
	// pin defaults
	output rbms_pkg::rbms_pins_t         o_pins
);
	import rbms_pkg::*;

	rbms_state_t state_q;
	rbms_state_t state_d;
	logic        sys_rst;
	logic        rom_mode;
	logic        rom_wait_done;
	logic        host_wait_done;
	logic        sys_rst_q;
	logic [31:0] rel_cyc_q;

	assign sys_rst  = i_reset || !i_system_reset_n;
	assign rom_mode = (o_boot_cfg.iface == RBMS_IF_ROM_2W0) ||
	                  (o_boot_cfg.iface == RBMS_IF_ROM_GPIO);

	initial begin
		if (ROM_DELAY_CYC < 1 || HOST_READY_CYC < 1) $error("delays must be nonzero");
	end

	////////////////////////////////////////////////////////////////////////
	// reset condition: held internal resets, oscillator on, PLL off
	always_ff @(posedge i_core_clk) begin
		sys_rst_q    <= sys_rst;
		o_core_reset <= sys_rst;           // RULE1 RULE2
		o_osc_enable <= 1'b1;              // RULE2
		o_pll_enable <= !sys_rst && (state_q != RBMS_ST_RESET); // RULE2
	end

	// test hardware reset follows only its own pin and i_reset
	always_ff @(posedge i_core_clk) begin
		o_test_reset <= i_reset || !i_test_logic_reset_n; // RULE3
	end

	////////////////////////////////////////////////////////////////////////
	// strap capture: latch the selection on the release edge only
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_boot_select <= `RBMS_BOOT_SEL_RESET;
		end else if (sys_rst_q && !sys_rst) begin
			o_boot_select <= i_boot_select;  // RULE5
		end
	end

	////////////////////////////////////////////////////////////////////////
	// boot sequencer
	always_comb begin
		state_d = state_q;
		case (state_q)
			RBMS_ST_RESET:   state_d = RBMS_ST_CONFIG;
			RBMS_ST_CONFIG: begin
				if (o_boot_cfg.iface == RBMS_IF_NONE) state_d = RBMS_ST_INVALID;
				else state_d = RBMS_ST_WAIT;  // RULE12
			end
			RBMS_ST_WAIT: begin
				if (!rom_mode || rom_wait_done) state_d = RBMS_ST_BOOT; // RULE14
			end
			RBMS_ST_BOOT:    state_d = RBMS_ST_BOOT;
			RBMS_ST_INVALID: state_d = RBMS_ST_INVALID;
			default:         state_d = RBMS_ST_RESET;
		endcase
	end

	// held one edge past release so the decode reads the freshly captured code
	always_ff @(posedge i_core_clk) begin
		if (sys_rst || sys_rst_q) state_q <= RBMS_ST_RESET; // RULE1 RULE5
		else state_q <= state_d;
	end

	// decode the captured code into interface, rate, role and address
	always_ff @(posedge i_core_clk) begin
		if (sys_rst || sys_rst_q) begin
			o_boot_cfg <= '0;
		end else if (state_q == RBMS_ST_RESET) begin
			o_boot_cfg <= '0;
			if (o_boot_select == `RBMS_BOOT_ROM_2W0) begin
				o_boot_cfg.iface  <= RBMS_IF_ROM_2W0;    // RULE6
				o_boot_cfg.rate   <= `RBMS_RATE_400K;
				o_boot_cfg.master <= 1'b1;
			end else if (o_boot_select == `RBMS_BOOT_ASYNC) begin
				o_boot_cfg.iface  <= RBMS_IF_ASYNC;      // RULE7
				o_boot_cfg.rate   <= `RBMS_RATE_384K;
			end else if (o_boot_select == `RBMS_BOOT_SPI) begin
				o_boot_cfg.iface  <= RBMS_IF_SPI;        // RULE8
				o_boot_cfg.rate   <= `RBMS_RATE_MASTER;
			end else if (o_boot_select == `RBMS_BOOT_ROM_GPIO) begin
				o_boot_cfg.iface  <= RBMS_IF_ROM_GPIO;   // RULE9
				o_boot_cfg.rate   <= `RBMS_RATE_384K;
				o_boot_cfg.master <= 1'b1;
			end else if (o_boot_select == `RBMS_BOOT_2W_SLAVE) begin
				o_boot_cfg.iface      <= RBMS_IF_2W_SLAVE; // RULE10
				o_boot_cfg.rate       <= `RBMS_RATE_MASTER;
				o_boot_cfg.slave_addr <= `RBMS_SLAVE_ADDR;
			end
		end
	end

	// start pulse and status flags
	always_ff @(posedge i_core_clk) begin
		if (sys_rst) begin
			o_boot_start   <= 1'b0;
			o_boot_invalid <= 1'b0;
			o_host_ready   <= 1'b0;
		end else begin
			o_boot_start   <= (state_q == RBMS_ST_WAIT) && (state_d == RBMS_ST_BOOT);
			o_boot_invalid <= (state_q == RBMS_ST_INVALID); // RULE11
			o_host_ready   <= host_wait_done;               // RULE13
		end
	end

	////////////////////////////////////////////////////////////////////////
	// release-to-boot delay timers, both started at reset release
	rbms_delay_timer #(.CYCLES(ROM_DELAY_CYC)) u_rom_delay (
		.i_core_clk (i_core_clk),
		.i_clear    (sys_rst),
		.i_start    (1'b1),
		.o_done     (rom_wait_done)
	);

	rbms_delay_timer #(.CYCLES(HOST_READY_CYC)) u_host_delay (
		.i_core_clk (i_core_clk),
		.i_clear    (sys_rst),
		.i_start    (1'b1),
		.o_done     (host_wait_done)
	);

	// plain count since release, kept apart from the timer that the start check guards
	always_ff @(posedge i_core_clk) begin
		if (sys_rst) begin
			rel_cyc_q <= 32'h0;
		end else if (rel_cyc_q != 32'hFFFFFFFF) begin
			rel_cyc_q <= rel_cyc_q + 32'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin defaults: pumps driven low, others inputs until firmware reloads
	always_ff @(posedge i_core_clk) begin
		if (sys_rst) begin
			o_pins.pump_high_o    <= 1'b0;  // RULE16
			o_pins.pump_high_oe   <= 1'b1;
			o_pins.pump_low_o     <= 1'b0;
			o_pins.pump_low_oe    <= 1'b1;
			o_pins.supply_sync_oe <= 1'b0;  // RULE17
			o_pins.aux_audio_oe   <= 4'h0;
		end else if (i_pin_cfg_load) begin
			o_pins <= i_pin_cfg;            // RULE16 RULE17
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	chk_rom_delay_min: assert property (@(posedge i_core_clk) disable iff (sys_rst)
		o_boot_start && rom_mode |-> rom_wait_done && rel_cyc_q >= ROM_DELAY_CYC) // RULE14
		else $error("rom boot started before delay");

	chk_pll_in_reset: assert property (@(posedge i_core_clk)
		sys_rst |=> !o_pll_enable && o_core_reset && o_osc_enable) // RULE2
		else $error("reset condition not held");

	chk_pump_low: assert property (@(posedge i_core_clk)
		sys_rst |=> !o_pins.pump_high_o && !o_pins.pump_low_o && o_pins.pump_high_oe) // RULE16
		else $error("pump not driven low in reset");

	chk_pins_input: assert property (@(posedge i_core_clk)
		sys_rst |=> !o_pins.supply_sync_oe && o_pins.aux_audio_oe == 4'h0) // RULE17
		else $error("reserved pins not inputs after reset");

	chk_strap_capture: assert property (@(posedge i_core_clk) disable iff (i_reset)
		$fell(sys_rst) |=> o_boot_select == $past(i_boot_select)) // RULE5
		else $error("boot select not captured");

	chk_strap_hold: assert property (@(posedge i_core_clk) disable iff (i_reset)
		!sys_rst && !sys_rst_q |=> $stable(o_boot_select)) // RULE5
		else $error("boot select changed after capture");

	chk_mode_rom0: assert property (@(posedge i_core_clk) disable iff (sys_rst)
		state_q == RBMS_ST_CONFIG && o_boot_select == 4'h1 |->
		o_boot_cfg.iface == RBMS_IF_ROM_2W0 && o_boot_cfg.rate == 3'h1) // RULE6
		else $error("mode 1 setup wrong");

	chk_mode_slave: assert property (@(posedge i_core_clk) disable iff (sys_rst)
		state_q == RBMS_ST_CONFIG && o_boot_select == 4'hC |->
		o_boot_cfg.slave_addr == 7'h44 && !o_boot_cfg.master) // RULE10
		else $error("mode C setup wrong");

	chk_cfg_before_start: assert property (@(posedge i_core_clk) disable iff (sys_rst)
		o_boot_start |-> o_boot_cfg.iface != RBMS_IF_NONE && $stable(o_boot_cfg)) // RULE12
		else $error("boot started without setup");

	chk_test_reset_own: assert property (@(posedge i_core_clk) disable iff (i_reset)
		!i_test_logic_reset_n && i_system_reset_n |=> !o_core_reset && o_test_reset) // RULE3
		else $error("test reset leaked into core");
endmodule
`default_nettype wire

// ==== rtl/rbms_regs.svh ====
// timing counts, reset values and boot codes of the reset and boot-mode block
`ifndef RBMS_REGS_SVH
`define RBMS_REGS_SVH
`define RBMS_CLK_PERIOD_NS    5
`define RBMS_ROM_DELAY_NS     2650000
`define RBMS_HOST_READY_NS    2400000
`define RBMS_ROM_DELAY_CYC    ((`RBMS_ROM_DELAY_NS + `RBMS_CLK_PERIOD_NS - 1) / `RBMS_CLK_PERIOD_NS)
`define RBMS_HOST_READY_CYC   (`RBMS_HOST_READY_NS / `RBMS_CLK_PERIOD_NS)
`define RBMS_BOOT_ROM_2W0     4'h1
`define RBMS_BOOT_ASYNC       4'h2
`define RBMS_BOOT_SPI         4'h3
`define RBMS_BOOT_ROM_GPIO    4'h7
`define RBMS_BOOT_2W_SLAVE    4'hC
`define RBMS_SLAVE_ADDR       7'h44
`define RBMS_RATE_NONE        3'h0
`define RBMS_RATE_400K        3'h1
`define RBMS_RATE_384K        3'h2
`define RBMS_RATE_MASTER      3'h3
`define RBMS_BOOT_SEL_RESET   4'h0
`endif

// ==== rtl/rbms_pkg.sv ====
// types shared by the reset and boot-mode block
package rbms_pkg;
	typedef enum logic [2:0] {
		RBMS_ST_RESET   = 3'b000,
		RBMS_ST_CONFIG  = 3'b001,
		RBMS_ST_WAIT    = 3'b010,
		RBMS_ST_BOOT    = 3'b011,
		RBMS_ST_INVALID = 3'b100
	} rbms_state_t;

	typedef enum logic [2:0] {
		RBMS_IF_NONE     = 3'b000,
		RBMS_IF_ROM_2W0  = 3'b001,
		RBMS_IF_ASYNC    = 3'b010,
		RBMS_IF_SPI      = 3'b011,
		RBMS_IF_ROM_GPIO = 3'b100,
		RBMS_IF_2W_SLAVE = 3'b101
	} rbms_iface_t;

	// boot interface setup handed to the boot engine
	typedef struct packed {
		rbms_iface_t iface;
		logic [2:0]  rate;
		logic        master;
		logic [6:0]  slave_addr;
	} rbms_boot_cfg_t;

	// reset-default pin controls (oe high = driven)
	typedef struct packed {
		logic       pump_high_o;
		logic       pump_high_oe;
		logic       pump_low_o;
		logic       pump_low_oe;
		logic       supply_sync_oe;
		logic [3:0] aux_audio_oe;
	} rbms_pins_t;
endpackage

// ==== rtl/rbms_delay_timer.sv ====
// one-shot cycle counter that flags when a programmed delay has elapsed
`timescale 1ns/10ps
`default_nettype none
module rbms_delay_timer #(
	parameter int unsigned CYCLES = 1
) (
	// clock and restart
	input  wire logic i_core_clk,
	input  wire logic i_clear,
	// arm and result
	input  wire logic i_start,
	output logic      o_done
);
	localparam int unsigned W = $clog2(CYCLES + 1);
	logic [W-1:0] cnt_q;
	logic         run_q;

	initial begin
		if (CYCLES < 1) $error("delay must be at least one cycle");
	end

	// count while running; done holds until cleared
	always_ff @(posedge i_core_clk) begin
		if (i_clear) begin
			cnt_q  <= '0;
			run_q  <= 1'b0;
			o_done <= 1'b0;
		end else if (i_start && !run_q && !o_done) begin
			run_q <= 1'b1;
			cnt_q <= W'(1);
		end else if (run_q) begin
			if (cnt_q == W'(CYCLES)) begin
				run_q  <= 1'b0;
				o_done <= 1'b1;
			end else begin
				cnt_q <= cnt_q + W'(1);
			end
		end
	end
endmodule
`default_nettype wire

// ==== verif/rbms_board_model.sv ====
// board-side model: reset pins, boot straps and host boot pacing
`timescale 1ns/10ps
`default_nettype none
module rbms_board_model #(
	parameter int unsigned READY_CYC = 13
) (
	// clock and bench requests
	input  wire logic       i_core_clk,
	input  wire logic       i_hold,
	input  wire logic       i_trst_only,
	input  wire logic       i_strap_en,
	input  wire logic [3:0] i_strap,
	// pins toward the device
	output logic            o_system_reset_n,
	output logic            o_test_logic_reset_n,
	output logic [3:0]      o_boot_select,
	output logic            o_host_go
);
	int unsigned wait_q;

	// both resets fall together so the test hardware starts clean
	assign o_system_reset_n     = !i_hold;
	assign o_test_logic_reset_n = !(i_hold || i_trst_only);
	// reserved codes only when the bench asks; undriven straps float high
	assign o_boot_select = i_strap_en ? i_strap : 4'hF;
	////////////////////////////////////////
	// host holds off its transfer until the ready time has run
	always_ff @(posedge i_core_clk) begin
		if (i_hold) begin
			wait_q <= 32'h0;
		end else if (wait_q < READY_CYC) begin
			wait_q <= wait_q + 32'h1;
		end
	end
	assign o_host_go = !i_hold && (wait_q >= READY_CYC);
endmodule
`default_nettype wire

// ==== verif/test_rbms_reset_boot.sv ====
// self-checking bench for the reset and boot-mode block
`timescale 1ns/10ps
`default_nettype none
module test_rbms_reset_boot;
	import rbms_pkg::*;
	localparam int unsigned ROM_CYC = 20;
	localparam int unsigned RDY_CYC = 10;
	// one row per strap code with the boot setup it should give
	typedef struct packed {
		logic [3:0]  code;
		rbms_iface_t iface;
		logic [2:0]  rate;
		logic        master;
		logic        valid;
	} rbms_row_t;
	rbms_row_t      tab [16];
	logic           clk = 1'b0, rst = 1'b1, hold = 1'b1, trst_only = 1'b0;
	logic           strap_en = 1'b1, pin_load = 1'b0;
	logic [3:0]     strap = 4'h0;
	rbms_pins_t     pin_cfg = '0;
	logic           sys_n, trst_n, host_go, core_rst, test_rst, osc_en, pll_en;
	logic           start, invalid, host_rdy;
	logic [3:0]     bsel, sel_q;
	rbms_boot_cfg_t cfg;
	rbms_pins_t     pins;
	int             fail_count = 0, checks_done = 0, n;

	always #2.5 clk = ~clk;

	rbms_board_model #(.READY_CYC(RDY_CYC + 3)) board (
		.i_core_clk(clk), .i_hold(hold), .i_trst_only(trst_only), .i_strap_en(strap_en),
		.i_strap(strap), .o_system_reset_n(sys_n), .o_test_logic_reset_n(trst_n),
		.o_boot_select(bsel), .o_host_go(host_go));
	rbms_reset_boot #(.ROM_DELAY_CYC(ROM_CYC), .HOST_READY_CYC(RDY_CYC)) uut (
		.i_core_clk(clk), .i_reset(rst), .i_system_reset_n(sys_n),
		.i_test_logic_reset_n(trst_n), .i_boot_select(bsel), .i_pin_cfg(pin_cfg),
		.i_pin_cfg_load(pin_load), .o_core_reset(core_rst), .o_test_reset(test_rst),
		.o_osc_enable(osc_en), .o_pll_enable(pll_en), .o_boot_select(sel_q),
		.o_boot_cfg(cfg), .o_boot_start(start), .o_boot_invalid(invalid),
		.o_host_ready(host_rdy), .o_pins(pins));
	////////////////////////////////////////
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// hold both reset pins, look at the reset state, then release
	task automatic boot(input logic [3:0] code);
		@(posedge clk);
		hold  <= 1'b1;
		strap <= code;
		repeat (3) @(posedge clk);
		@(negedge clk);
		check("core_reset", core_rst, 1'b1);
		check("osc_enable", osc_en, 1'b1);
		check("pll_enable", pll_en, 1'b0);
		check("test_reset", test_rst, 1'b1);
		check("boot_cfg", cfg, '0);
		check("pins", pins, 9'h0A0);
		@(posedge clk);
		hold <= 1'b0;
	endtask

	// bounded wait for the start pulse, counting cycles from release
	task automatic wait_start();
		n = 0;
		while (start !== 1'b1 && n < 60) begin
			@(negedge clk);
			n++;
		end
	endtask
	////////////////////////////////////////
	initial begin
		for (int c = 0; c < 16; c++) tab[c] = '{c[3:0], RBMS_IF_NONE, 3'h0, 1'b0, 1'b0};
		tab[1]  = '{4'h1, RBMS_IF_ROM_2W0, 3'h1, 1'b1, 1'b1};
		tab[2]  = '{4'h2, RBMS_IF_ASYNC, 3'h2, 1'b0, 1'b1};
		tab[3]  = '{4'h3, RBMS_IF_SPI, 3'h3, 1'b0, 1'b1};
		tab[7]  = '{4'h7, RBMS_IF_ROM_GPIO, 3'h2, 1'b1, 1'b1};
		tab[12] = '{4'hC, RBMS_IF_2W_SLAVE, 3'h3, 1'b0, 1'b1};
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		foreach (tab[i]) begin
			boot(tab[i].code);
			wait_start();
			check("boot_start", start, tab[i].valid);
			if (tab[i].iface inside {RBMS_IF_ROM_2W0, RBMS_IF_ROM_GPIO}) begin
				check("rom_wait", n >= ROM_CYC && n <= ROM_CYC + 8, 1'b1);
			end else if (tab[i].valid) begin
				check("start_wait", n <= 8, 1'b1);
			end
			@(posedge clk);
			strap <= ~tab[i].code;
			repeat (2) @(negedge clk);
			check("boot_select", sel_q, tab[i].code);
			check("invalid", invalid, !tab[i].valid);
			check("iface", cfg.iface, tab[i].iface);
			check("pll_enable", pll_en, 1'b1);
			if (tab[i].valid) begin
				check("rate", cfg.rate, tab[i].rate);
				check("master", cfg.master, tab[i].master);
			end
		end
		// host boot: ready level only after its wait
		boot(4'hC);
		wait_start();
		check("host_ready", host_rdy, 1'b0);
		check("slave_addr", cfg.slave_addr, 7'h44);
		while (host_go !== 1'b1 && n < 80) begin
			@(negedge clk);
			n++;
		end
		check("host_ready", host_rdy, 1'b1);
		// second reset cuts a rom wait short; the delay restarts in full
		boot(4'h1);
		repeat (10) @(negedge clk);
		boot(4'h1);
		wait_start();
		check("rom_wait", n >= ROM_CYC, 1'b1);
		// firmware reassigns the pins, then test reset alone leaves them
		@(posedge clk);
		pin_cfg  <= 9'h15F;
		pin_load <= 1'b1;
		@(posedge clk);
		pin_load  <= 1'b0;
		trst_only <= 1'b1;
		repeat (3) @(negedge clk);
		check("pins", pins, 9'h15F);
		check("test_reset", test_rst, 1'b1);
		check("core_reset", core_rst, 1'b0);
		check("boot_select", sel_q, 4'h1);
		@(posedge clk);
		trst_only <= 1'b0;
		strap_en  <= 1'b0;
		repeat (2) @(negedge clk);
		check("test_reset", test_rst, 1'b0);
		// straps left floating read as all ones, a reserved code
		boot(4'h1);
		wait_start();
		check("boot_select", sel_q, 4'hF);
		check("invalid", invalid, 1'b1);
		results();
	end

	// hang guard, well beyond the expected run length
	initial begin
		repeat (6000) @(posedge clk);
		fail_count++;
		results();
	end
endmodule
`default_nettype wire
